/* File: rtl/p2pm_pkg.sv */
// port 2 pin mux: register map, field positions, reset values and modes
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package p2pm_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_SEL_A = 8'h00;
  localparam logic [7:0] ADDR_SEL_B = 8'h04;
  localparam logic [7:0] ADDR_GCFG_LOW = 8'h08;
  localparam logic [7:0] ADDR_GCFG_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_GP_DATA = 8'h10;
  localparam logic [7:0] ADDR_GP_DIR = 8'h14;
  localparam logic [7:0] ADDR_GP_ALT = 8'h18;
  localparam logic [7:0] ADDR_GP_LEVEL = 8'h1c;
  localparam logic [7:0] ADDR_HS_UART_A = 8'h20;
  localparam logic [7:0] ADDR_HS_UART_B = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;

  // ==========================================================
  // reset values
  localparam logic [7:0] SEL_A_RESET = 8'h00;
  localparam logic [7:0] SEL_B_RESET = 8'h00;
  localparam logic [7:0] GCFG_RESET = 8'h00;
  localparam logic [5:0] GP_RESET = 6'h00;

  // ==========================================================
  // field positions
  localparam int SELB_LINE1_LO = 3;
  localparam int SELB_LINE2_BIT = 5;
  localparam int SELB_LINE3_LO = 6;
  localparam int SELA_LINE4_LO = 4;
  localparam int GCL_DEFAULT_CLEAR_BIT = 0;
  localparam int GCL_KBD_ENABLE_BIT = 2;
  localparam int GCL_CLOCK48_BIT = 6;
  localparam int GCH_CFG_PORT_BIT = 6;
  localparam int HS_CTS_BIT = 4;
  localparam int STAT_STRAP_PHASE_BIT = 0;
  localparam int STAT_PM_EVENT_BIT = 1;

  // strap pin indices in the strap vectors
  localparam int STRAP_A_RTS = 0;
  localparam int STRAP_A_DTR = 1;
  localparam int STRAP_A_SOUT = 2;
  localparam int STRAP_B_SOUT = 3;

  // ==========================================================
  // 2-bit select codes
  localparam logic [1:0] MODE_DEFAULT = 2'b00;
  localparam logic [1:0] MODE_GP = 2'b01;
  localparam logic [1:0] MODE_ALT = 2'b10;

  // what a port 2 pin currently does
  typedef enum logic [2:0]
  {
    P2PM_ROLE_NONE,
    P2PM_ROLE_GP,
    P2PM_ROLE_PM_INT,
    P2PM_ROLE_KBD_LINE6,
    P2PM_ROLE_PANEL_OUT,
    P2PM_ROLE_PANEL_IN,
    P2PM_ROLE_KBD_LINE3
  } p2pm_role_t;

endpackage

/* File: rtl/p2pm_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the pclk domain
`timescale 1ns/1ps
module p2pm_sync #(
  parameter int WIDTH = 1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // stage1 feeds only sync_out, never any other logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: rtl/p2pm_top.sv */
// port 2 pin function mux with power-on strap capture and apb registers
// assumes pins pass through pads outside; weak pull-downs are enabled by strap_pulldown_en
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

module p2pm_top
  import p2pm_pkg::*;
#(
  parameter int LINES = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_reset,
  input wire logic [LINES-1:0] port2_line_in,
  output logic [LINES-1:0] port2_line_out,
  output logic [LINES-1:0] port2_line_oe,
  input wire logic keyboard_reset_out,
  input wire logic addr_line20_gate,
  input wire logic [6:3] kbd_port1_drive,
  output logic [6:3] kbd_port1_level,
  input wire logic pm_event,
  input wire logic acpi_mode,
  output logic acpi_control_interrupt,
  input wire logic panel_switch_output,
  output logic panel_switch_input,
  input wire logic [3:0] strap_uart_drive,
  input wire logic [3:0] strap_pin_in,
  output logic [3:0] strap_pin_out,
  output logic [3:0] strap_pin_oe,
  output logic strap_pulldown_en,
  input wire logic uart_a_clear_to_send,
  input wire logic uart_b_clear_to_send,
  output logic [7:0] global_config_low,
  output logic [7:0] global_config_high
);

  // ==========================================================
  // declarations
  localparam int SYNC_W = LINES + 7;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  logic [LINES-1:0] line_lvl;
  logic [3:0] strap_lvl;
  logic cts_a_lvl;
  logic cts_b_lvl;
  logic mreset_lvl;
  logic mreset_prev;
  logic strap_phase;
  logic capture;
  logic [7:0] pin_function_select_a;
  logic [7:0] pin_function_select_b;
  logic [LINES-1:0] gp_data;
  logic [LINES-1:0] gp_dir;
  logic [LINES-1:0] gp_alt;
  logic power_mgmt_interrupt_n;
  logic [LINES-1:0] alt_val;
  logic [LINES-1:0] alt_od;
  logic [LINES-1:0] next_line_out;
  logic [LINES-1:0] next_line_oe;
  logic [6:3] next_kbd_level;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] next_prdata;

  // ==========================================================
  // pin synchronisers
  assign sync_raw = {master_reset, uart_b_clear_to_send, uart_a_clear_to_send, strap_pin_in, port2_line_in};

  p2pm_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );

  assign line_lvl = sync_lvl[LINES-1:0];
  assign strap_lvl = sync_lvl[LINES+3:LINES];
  assign cts_a_lvl = sync_lvl[LINES+4];
  assign cts_b_lvl = sync_lvl[LINES+5];
  assign mreset_lvl = sync_lvl[LINES+6];

  // ==========================================================
  // role of each port 2 pin from the select fields
  function automatic p2pm_role_t line_role(input logic [2:0] idx, input logic [7:0] sa, input logic [7:0] sb);
    p2pm_role_t r;
    r = P2PM_ROLE_NONE;
    unique case (idx)
      3'd0, 3'd5: r = P2PM_ROLE_GP;
      3'd1:
      begin
        unique case (sb[SELB_LINE1_LO +: 2])
          MODE_DEFAULT: r = P2PM_ROLE_PM_INT;
          MODE_GP: r = P2PM_ROLE_GP;
          MODE_ALT: r = P2PM_ROLE_KBD_LINE6;
          default: r = P2PM_ROLE_NONE;
        endcase
      end
      3'd2: r = sb[SELB_LINE2_BIT] ? P2PM_ROLE_GP : P2PM_ROLE_PANEL_OUT;
      3'd3:
      begin
        unique case (sb[SELB_LINE3_LO +: 2])
          MODE_DEFAULT: r = P2PM_ROLE_PANEL_IN;
          MODE_GP: r = P2PM_ROLE_GP;
          default: r = P2PM_ROLE_NONE;
        endcase
      end
      3'd4:
      begin
        unique case (sa[SELA_LINE4_LO +: 2])
          MODE_GP: r = P2PM_ROLE_GP;
          MODE_ALT: r = P2PM_ROLE_KBD_LINE3;
          default: r = P2PM_ROLE_NONE;
        endcase
      end
      default: r = P2PM_ROLE_NONE;
    endcase
    return r;
  endfunction

  // ==========================================================
  // master reset edge and strap capture
  // the capture edge is the first cycle the synced master reset reads low
  assign capture = mreset_prev && !mreset_lvl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mreset_prev <= 1'b0;
    end
    else
    begin
      mreset_prev <= mreset_lvl;
    end
  end

  // strap phase: pins released and pulled down while master reset is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_phase <= 1'b1;
    end
    else if (mreset_lvl)
    begin
      strap_phase <= 1'b1;
    end
    else if (capture)
    begin
      strap_phase <= 1'b0;
    end
  end

  assign strap_pulldown_en = strap_phase;

  // ==========================================================
  // strap pins: uart drive once the strap phase is over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_pin_out <= 4'h0;
      strap_pin_oe <= 4'h0;
    end
    else
    begin
      strap_pin_out <= strap_uart_drive;
      strap_pin_oe <= {4{~strap_phase && !capture}};
    end
  end

  // ==========================================================
  // apb decode
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    unique case (paddr)
      ADDR_SEL_A, ADDR_SEL_B, ADDR_GCFG_LOW, ADDR_GCFG_HIGH, ADDR_GP_DATA, ADDR_GP_DIR, ADDR_GP_ALT,
      ADDR_GP_LEVEL, ADDR_HS_UART_A, ADDR_HS_UART_B, ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error in the access phase
  assign pslverr = psel && penable && !addr_ok;

  // ==========================================================
  // pin function selects; master reset restores the defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_function_select_a <= SEL_A_RESET;
      pin_function_select_b <= SEL_B_RESET;
    end
    else if (mreset_lvl)
    begin
      pin_function_select_a <= SEL_A_RESET;
      pin_function_select_b <= SEL_B_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_SEL_A)
        pin_function_select_a <= pwdata[7:0];
      if (paddr == ADDR_SEL_B)
        pin_function_select_b <= pwdata[7:0];
    end
  end

  // ==========================================================
  // global config; the strap capture wins over a write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_config_low <= GCFG_RESET;
      global_config_high <= GCFG_RESET;
    end
    else if (capture)
    begin
      global_config_low[GCL_DEFAULT_CLEAR_BIT] <= strap_lvl[STRAP_A_DTR];
      global_config_low[GCL_KBD_ENABLE_BIT] <= strap_lvl[STRAP_A_SOUT];
      global_config_low[GCL_CLOCK48_BIT] <= strap_lvl[STRAP_B_SOUT];
      global_config_high[GCH_CFG_PORT_BIT] <= strap_lvl[STRAP_A_RTS];
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_GCFG_LOW)
        global_config_low <= pwdata[7:0];
      if (paddr == ADDR_GCFG_HIGH)
        global_config_high <= pwdata[7:0];
    end
  end

  // ==========================================================
  // general purpose port 2 registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_data <= GP_RESET;
      gp_dir <= GP_RESET;
      gp_alt <= GP_RESET;
    end
    else if (mreset_lvl)
    begin
      gp_dir <= GP_RESET;
      gp_alt <= GP_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_GP_DATA)
        gp_data <= pwdata[LINES-1:0];
      if (paddr == ADDR_GP_DIR)
        gp_dir <= pwdata[LINES-1:0];
      if (paddr == ADDR_GP_ALT)
        gp_alt <= pwdata[LINES-1:0];
    end
  end

  // ==========================================================
  // power management interrupt, active low on the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_mgmt_interrupt_n <= 1'b1;
      acpi_control_interrupt <= 1'b0;
    end
    else
    begin
      power_mgmt_interrupt_n <= ~pm_event;
      acpi_control_interrupt <= pm_event && acpi_mode;
    end
  end

  // ==========================================================
  // alternate functions of the gp lines
  // kbd port1 lines are quasi-bidirectional: they only pull low
  always_comb
  begin
    alt_val[0] = keyboard_reset_out;
    alt_od[0] = 1'b0;
    alt_val[1] = kbd_port1_drive[3];
    alt_od[1] = 1'b1;
    alt_val[2] = kbd_port1_drive[4];
    alt_od[2] = 1'b1;
    alt_val[3] = kbd_port1_drive[5];
    alt_od[3] = 1'b1;
    alt_val[4] = kbd_port1_drive[6];
    alt_od[4] = 1'b1;
    alt_val[5] = addr_line20_gate;
    alt_od[5] = 1'b0;
  end

  // ==========================================================
  // per pin drive and enable
  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      next_line_out[i] = 1'b0;
      next_line_oe[i] = 1'b0;
      unique case (line_role(3'(i), pin_function_select_a, pin_function_select_b))
        P2PM_ROLE_GP:
        begin
          if (gp_alt[i] && alt_od[i])
            next_line_oe[i] = ~alt_val[i];
          else if (gp_alt[i])
          begin
            next_line_out[i] = alt_val[i];
            next_line_oe[i] = 1'b1;
          end
          else
          begin
            next_line_out[i] = gp_data[i];
            next_line_oe[i] = gp_dir[i];
          end
        end
        P2PM_ROLE_PM_INT:
        begin
          next_line_out[i] = power_mgmt_interrupt_n;
          next_line_oe[i] = 1'b1;
        end
        P2PM_ROLE_KBD_LINE6:
          next_line_oe[i] = ~kbd_port1_drive[6];
        P2PM_ROLE_KBD_LINE3:
          next_line_oe[i] = ~kbd_port1_drive[3];
        P2PM_ROLE_PANEL_OUT:
        begin
          next_line_out[i] = panel_switch_output;
          next_line_oe[i] = 1'b1;
        end
        P2PM_ROLE_PANEL_IN, P2PM_ROLE_NONE:
          next_line_oe[i] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // kbd port1 levels: wired-and of every pin carrying each line
  always_comb
  begin
    next_kbd_level = 4'hf;
    for (int i = 1; i < 5; i++)
    begin
      if (line_role(3'(i), pin_function_select_a, pin_function_select_b) == P2PM_ROLE_GP && gp_alt[i])
        next_kbd_level[i + 2] = next_kbd_level[i + 2] & line_lvl[i];
    end
    if (line_role(3'd1, pin_function_select_a, pin_function_select_b) == P2PM_ROLE_KBD_LINE6)
      next_kbd_level[6] = next_kbd_level[6] & line_lvl[1];
    if (line_role(3'd4, pin_function_select_a, pin_function_select_b) == P2PM_ROLE_KBD_LINE3)
      next_kbd_level[3] = next_kbd_level[3] & line_lvl[4];
  end

  // ==========================================================
  // registered pin outputs and inward levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port2_line_out <= '0;
      port2_line_oe <= '0;
      kbd_port1_level <= 4'hf;
      panel_switch_input <= 1'b1;
    end
    else
    begin
      port2_line_out <= next_line_out;
      port2_line_oe <= next_line_oe;
      kbd_port1_level <= next_kbd_level;
      // panel input holds high when the pin is given to port 2
      if (line_role(3'd3, pin_function_select_a, pin_function_select_b) == P2PM_ROLE_PANEL_IN)
        panel_switch_input <= line_lvl[3];
      else
        panel_switch_input <= 1'b1;
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle and held for the access
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_SEL_A: next_prdata[7:0] = pin_function_select_a;
      ADDR_SEL_B: next_prdata[7:0] = pin_function_select_b;
      ADDR_GCFG_LOW: next_prdata[7:0] = global_config_low;
      ADDR_GCFG_HIGH: next_prdata[7:0] = global_config_high;
      ADDR_GP_DATA: next_prdata[LINES-1:0] = gp_data;
      ADDR_GP_DIR: next_prdata[LINES-1:0] = gp_dir;
      ADDR_GP_ALT: next_prdata[LINES-1:0] = gp_alt;
      ADDR_GP_LEVEL: next_prdata[LINES-1:0] = line_lvl;
      ADDR_HS_UART_A: next_prdata[HS_CTS_BIT] = cts_a_lvl;
      ADDR_HS_UART_B: next_prdata[HS_CTS_BIT] = cts_b_lvl;
      ADDR_STATUS:
      begin
        next_prdata[STAT_STRAP_PHASE_BIT] = strap_phase;
        next_prdata[STAT_PM_EVENT_BIT] = pm_event;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= next_prdata;
  end

endmodule

/* File: verification/p2pm_monitor.sv */
// checker for strap capture, acpi interrupt and cts readback
// assumes it is bound to p2pm_top and sees only its ports
`timescale 1ns/1ps
module p2pm_monitor
  import p2pm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic master_reset,
  input wire logic pm_event,
  input wire logic acpi_mode,
  input wire logic acpi_control_interrupt,
  input wire logic [3:0] strap_uart_drive,
  input wire logic [3:0] strap_pin_in,
  input wire logic [3:0] strap_pin_out,
  input wire logic [3:0] strap_pin_oe,
  input wire logic strap_pulldown_en,
  input wire logic uart_a_clear_to_send,
  input wire logic [7:0] global_config_low,
  input wire logic [7:0] global_config_high
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // strap phase
  // five samples leave room for the two sync flops
  property p_strap_hold;
    master_reset [*5] |-> strap_pulldown_en && strap_pin_oe == 4'h0;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap pins driven in reset");
  property p_strap_end;
    master_reset [*3] ##1 !master_reset [*5] |-> !strap_pulldown_en;
  endproperty
  a_strap_end: assert property (p_strap_end) else $error("strap phase did not end");
  property p_uart_back;
    !strap_pulldown_en [*2] |-> strap_pin_oe == 4'hf && strap_pin_out == $past(strap_uart_drive);
  endproperty
  a_uart_back: assert property (p_uart_back) else $error("strap pins not back to uart");
  // ==========================================
  // captured levels, taken while pull-downs were still on
  property p_cap_rts;
    $fell(strap_pulldown_en) |-> global_config_high[GCH_CFG_PORT_BIT] == $past(strap_pin_in[STRAP_A_RTS]);
  endproperty
  a_cap_rts: assert property (p_cap_rts) else $error("rts strap wrong");
  property p_cap_dtr;
    $fell(strap_pulldown_en) |-> global_config_low[GCL_DEFAULT_CLEAR_BIT] == $past(strap_pin_in[STRAP_A_DTR]);
  endproperty
  a_cap_dtr: assert property (p_cap_dtr) else $error("dtr strap wrong");
  property p_cap_sout_a;
    $fell(strap_pulldown_en) |-> global_config_low[GCL_KBD_ENABLE_BIT] == $past(strap_pin_in[STRAP_A_SOUT]);
  endproperty
  a_cap_sout_a: assert property (p_cap_sout_a) else $error("uart a sout strap wrong");
  property p_cap_sout_b;
    $fell(strap_pulldown_en) |-> global_config_low[GCL_CLOCK48_BIT] == $past(strap_pin_in[STRAP_B_SOUT]);
  endproperty
  a_cap_sout_b: assert property (p_cap_sout_b) else $error("uart b sout strap wrong");
  // ==========================================
  // acpi interrupt and cts readback
  property p_acpi_on;
    (pm_event && acpi_mode) [*2] |-> acpi_control_interrupt;
  endproperty
  a_acpi_on: assert property (p_acpi_on) else $error("acpi interrupt missing");
  property p_acpi_off;
    !acpi_mode [*2] |-> !acpi_control_interrupt;
  endproperty
  a_acpi_off: assert property (p_acpi_off) else $error("acpi interrupt outside acpi mode");
  sequence s_cts_read;
    $stable(uart_a_clear_to_send) [*4] ##0 (psel && !penable && !pwrite && paddr == ADDR_HS_UART_A);
  endsequence
  property p_cts;
    s_cts_read |=> prdata[HS_CTS_BIT] == uart_a_clear_to_send;
  endproperty
  a_cts: assert property (p_cts) else $error("cts bit wrong");
  c_capture: cover property ($fell(strap_pulldown_en));
  c_acpi: cover property (acpi_control_interrupt);
  c_cts: cover property (s_cts_read);
endmodule

bind p2pm_top p2pm_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .master_reset,
  .pm_event, .acpi_mode, .acpi_control_interrupt, .strap_uart_drive, .strap_pin_in, .strap_pin_out,
  .strap_pin_oe, .strap_pulldown_en, .uart_a_clear_to_send, .global_config_low, .global_config_high);

/* File: verification/p2pm_board.sv */
// board model: pull-ups, panel switch and strap resistors
// assumes pad drive and enable of p2pm_top resolve into levels here
`timescale 1ns/1ps
module p2pm_board (
  input wire logic pclk,
  input wire logic [5:0] line_out,
  input wire logic [5:0] line_oe,
  input wire logic panel_sw,
  output logic [5:0] line_in,
  input wire logic [3:0] strap_out,
  input wire logic [3:0] strap_oe,
  input wire logic [3:0] strap_up,
  input wire logic pd_en,
  output logic [3:0] strap_in
);
  logic flt = 1'h0;
  // a strap line with nothing on it wanders, never holds its last value
  always @(posedge pclk) flt <= ~flt;
  // port 2 lines have pull-ups, except line 3, which sees the panel switch instead
  always_comb
    for (int i = 0; i < 6; i++)
      line_in[i] = line_oe[i] ? line_out[i] : (i == 3 ? panel_sw : 1'h1);
  // an external pull-up beats the weak internal pull-down
  always_comb
    for (int i = 0; i < 4; i++)
      strap_in[i] = strap_oe[i] ? strap_out[i] : strap_up[i] ? 1'h1 : pd_en ? 1'h0 : flt ^ i[0];
endmodule

/* File: verification/tb_top.sv */
// scenarios for the port 2 pin mux and strap capture
// assumes p2pm_board stands for pull resistors and switches
`timescale 1ns/1ps
module tb_top;
  import p2pm_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, acpi_int, panel_in, pd_en;
  logic master_reset = 1'h0, kbd_rst = 1'h0, a20 = 1'h0, pm_ev = 1'h0, acpi_mode = 1'h0;
  logic panel_out = 1'h0, cts_a = 1'h0, cts_b = 1'h0, panel_sw = 1'h1;
  logic [3:0] kbd_drive = 4'hf, uart_drive = 4'h6, strap_up = 4'h0;
  logic [3:0] kbd_level, strap_in, strap_out, strap_oe;
  logic [5:0] line_in, line_out, line_oe;
  logic [7:0] gcl, gch;
  int failures = 0, n_checks = 0;
  always #10 pclk = ~pclk;
  p2pm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset(master_reset), .port2_line_in(line_in), .port2_line_out(line_out),
    .port2_line_oe(line_oe), .keyboard_reset_out(kbd_rst), .addr_line20_gate(a20),
    .kbd_port1_drive(kbd_drive), .kbd_port1_level(kbd_level), .pm_event(pm_ev),
    .acpi_mode(acpi_mode), .acpi_control_interrupt(acpi_int), .panel_switch_output(panel_out),
    .panel_switch_input(panel_in), .strap_uart_drive(uart_drive), .strap_pin_in(strap_in),
    .strap_pin_out(strap_out), .strap_pin_oe(strap_oe), .strap_pulldown_en(pd_en),
    .uart_a_clear_to_send(cts_a), .uart_b_clear_to_send(cts_b), .global_config_low(gcl),
    .global_config_high(gch));
  p2pm_board board_u (.pclk(pclk), .line_out(line_out), .line_oe(line_oe), .panel_sw(panel_sw),
    .line_in(line_in), .strap_out(strap_out), .strap_oe(strap_oe), .strap_up(strap_up),
    .pd_en(pd_en), .strap_in(strap_in));
  // ==========================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; an idle cycle follows so psel is never driven twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'h1 && i < 16);
    rd = prdata;
    err = pslverr;
    if (i >= 16)
    begin
      failures++;
      final_report;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(1'h0, ADDR_SEL_A, 32'h0);
    chk(rd, SEL_A_RESET);
    apb(1'h0, ADDR_SEL_B, 32'h0);
    chk(rd, SEL_B_RESET);
    apb(1'h0, 8'hfc, 32'h0);
    // error flag and data compared apart: a 33-bit pair would lose the flag
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk({pd_en, strap_oe}, 5'h10);
    $display("t_reset done");
  endtask
  task automatic t_strap(input logic [3:0] p);
    strap_up <= p;
    master_reset <= 1'h1;
    tk(6);
    chk({pd_en, strap_oe}, 5'h10);
    master_reset <= 1'h0;
    tk(6);
    chk(gcl & 8'h45, {1'h0, p[3], 3'h0, p[2], 1'h0, p[1]});
    chk(gch & 8'h40, {1'h0, p[0], 6'h0});
    chk({strap_oe, strap_out}, {4'hf, uart_drive});
    apb(1'h0, ADDR_GCFG_HIGH, 32'h0);
    chk(rd & 32'h40, {p[0], 6'h0});
    $display("t_strap done");
  endtask
  // gp data set high on every line must not leak into non-gp functions
  task automatic t_default;
    apb(1'h1, ADDR_GP_DIR, 32'h3f);
    apb(1'h1, ADDR_GP_DATA, 32'h3f);
    acpi_mode <= 1'h1;
    pm_ev <= 1'h1;
    panel_sw <= 1'h0;
    tk(5);
    chk({line_oe[1], line_out[1], acpi_int}, 3'h5);
    chk({line_oe[2], line_out[2]}, 2'h2);
    chk({line_oe[3], panel_in}, 2'h0);
    acpi_mode <= 1'h0;
    pm_ev <= 1'h0;
    panel_out <= 1'h1;
    panel_sw <= 1'h1;
    tk(5);
    chk({line_out[1], acpi_int, line_out[2], panel_in}, 4'hb);
    // outside acpi mode a pm event still pulls the pin low, no acpi interrupt
    pm_ev <= 1'h1;
    tk(5);
    chk({line_oe[1], line_out[1], acpi_int}, 3'h4);
    pm_ev <= 1'h0;
    $display("t_default done");
  endtask
  task automatic t_gp;
    apb(1'h1, ADDR_SEL_B, 32'h68);
    apb(1'h1, ADDR_SEL_A, 32'h10);
    apb(1'h1, ADDR_GP_DATA, 32'h2a);
    tk(3);
    chk({line_oe, line_out}, 12'hfea);
    apb(1'h0, ADDR_GP_LEVEL, 32'h0);
    chk(rd, 32'h2a);
    apb(1'h1, ADDR_GP_ALT, 32'h21);
    kbd_rst <= 1'h1;
    tk(3);
    chk({line_out[5], line_out[0]}, 2'h1);
    kbd_rst <= 1'h0;
    a20 <= 1'h1;
    tk(3);
    chk({line_out[5], line_out[0]}, 2'h2);
    $display("t_gp done");
  endtask
  // lines 1..4 carry kbd port1 lines 6, 4, 5, 3, each once
  task automatic t_kbd;
    apb(1'h1, ADDR_GP_ALT, 32'h0c);
    apb(1'h1, ADDR_SEL_B, 32'h70);
    apb(1'h1, ADDR_SEL_A, 32'h20);
    for (int k = 0; k < 16; k += 5)
    begin
      kbd_drive <= k[3:0];
      tk(6);
      chk(kbd_level, k[3:0]);
    end
    $display("t_kbd done");
  endtask
  task automatic t_cts;
    for (int k = 0; k < 2; k++)
    begin
      cts_a <= k[0];
      cts_b <= !k[0];
      tk(4);
      apb(1'h0, ADDR_HS_UART_A, 32'h0);
      chk(rd[HS_CTS_BIT], k[0]);
      apb(1'h0, ADDR_HS_UART_B, 32'h0);
      chk(rd[HS_CTS_BIT], !k[0]);
    end
    $display("t_cts done");
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    tk(4);
    presetn <= 1'h1;
    tk(1);
    t_reset;
    t_strap(4'ha);
    t_strap(4'h5);
    t_default;
    t_gp;
    t_kbd;
    t_cts;
    final_report;
  end
endmodule
